// ### core/engine_serial_link_uart.sv
/*
 holds the transmit fifo and the full-duplex asynchronous serial link uart of the drive engine.
 assumes one 50 MHz clock, an asynchronous active-low reset, and a data path controller
 that drives rxd and farEndReadyN asynchronously to clk.
*/
// Functional notes
// - link uses only txd, rxd, farEndReadyN and engineReadyN, no shared clock.
// - device sends acknowledges and information on txd, paced by farEndReadyN.
// - engineReadyN low only while receive buffer free, high while occupied.
// - frames are asynchronous; receiver times bits from each start edge.
// - frame starts with low start bit, then eight data bits.
// - then an even parity bit, then a high stop bit.
// - every frame spans eleven bit periods, start through stop.
// - transmit and receive paths run independently, sharing only the bit rate select.
// - three bit rates derived from the system clock, within stated error.
// - writing the transmit buffer loads a byte and sends it when far end ready.
// - reading the receive buffer returns the first byte received since the last read and frees the buffer.
// - status shows transmit buffer empty and receive byte available.
// - bit rate select chooses one of the three bit rates.
`timescale 1ns/10ps
`include "esl_params.svh"

// ------------------------------------------
// synchronous fifo
// ------------------------------------------
module esl_fifo #(
   parameter int WIDTH = `ESL_DATA_BITS,
   parameter int DEPTH = `ESL_TX_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("esl_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtrQ;
   logic [AW:0] rdPtrQ;
   logic doWrite;
   logic doRead;

   // full when pointers differ only in the wrap bit
   assign inReady = (wrPtrQ[AW] == rdPtrQ[AW]) || (wrPtrQ[AW-1:0] != rdPtrQ[AW-1:0]);
   assign outValid = (wrPtrQ != rdPtrQ);
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   assign outData = mem[rdPtrQ[AW-1:0]];

   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtrQ[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrPtrQ <= '0;
      end else if (doWrite) begin
         wrPtrQ <= wrPtrQ + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdPtrQ <= '0;
      end else if (doRead) begin
         rdPtrQ <= rdPtrQ + (AW+1)'(1);
      end
   end
endmodule : esl_fifo

// ------------------------------------------
// serial link uart top
// ------------------------------------------
module engine_serial_link_uart #(
   parameter int CLK_HZ = `ESL_CLK_HZ,
   parameter int FIFO_DEPTH = `ESL_TX_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] bitRateSelect,
   input wire logic txWrite,
   input wire logic [7:0] txWriteData,
   output logic txWriteReady,
   input wire logic rxRead,
   output logic [7:0] rxReadData,
   output logic rxAvailable,
   output logic txBufferEmpty,
   output logic rxParityError,
   output logic rxFramingError,
   output logic rxOverrun,
   output logic txd,
   input wire logic rxd,
   input wire logic farEndReadyN,
   output logic engineReadyN
);
   localparam int CW = `ESL_CNT_W;

   generate
      if (CLK_HZ / `ESL_RATE_SLOW_BPS >= (1 << CW) || CLK_HZ / `ESL_RATE_FAST_BPS < 4) begin : g_bad_clk
         $error("engine_serial_link_uart: CLK_HZ out of range for the bit counters");
      end
   endgenerate

   function automatic logic [CW-1:0] bitCycles(input logic [1:0] sel);
      logic [CW-1:0] n;
      n = CW'((CLK_HZ + `ESL_RATE_SLOW_BPS / 2) / `ESL_RATE_SLOW_BPS);
      if (sel == `ESL_SEL_FAST) begin
         n = CW'((CLK_HZ + `ESL_RATE_FAST_BPS / 2) / `ESL_RATE_FAST_BPS);
      end else if (sel == `ESL_SEL_MID) begin
         n = CW'((CLK_HZ + `ESL_RATE_MID_BPS / 2) / `ESL_RATE_MID_BPS);
      end
      return n;
   endfunction : bitCycles

   // ------------------------------------------
   // reset release and input synchronisers
   // ------------------------------------------
   logic [1:0] rstPipeQ;
   logic rstN;
   logic [1:0] rxSyncQ;
   logic [1:0] farSyncQ;
   logic rxPrevQ;
   logic rxLine;
   logic farReady;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstPipeQ <= 2'h0;
      end else begin
         rstPipeQ <= {rstPipeQ[0], 1'b1};
      end
   end
   assign rstN = rstPipeQ[1];

   // two incoming link lines, no clock
   // idle line levels preset so release shows no false edge
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxSyncQ <= 2'h3;
         farSyncQ <= 2'h3;
         rxPrevQ <= 1'b1;
      end else begin
         rxSyncQ <= {rxSyncQ[0], rxd};
         farSyncQ <= {farSyncQ[0], farEndReadyN};
         rxPrevQ <= rxSyncQ[1];
      end
   end
   assign rxLine = rxSyncQ[1];
   assign farReady = !farSyncQ[1];

   // ------------------------------------------
   // transmit path
   // ------------------------------------------
   esl_pkg::esl_tx_state_t txStateQ;
   logic fifoValid;
   logic fifoPop;
   logic [7:0] fifoData;
   logic [CW-1:0] txDiv;
   logic [CW-1:0] txCntQ;
   logic [3:0] txIdxQ;
   logic [9:0] txShiftQ;
   logic txdQ;
   logic txLoad;
   logic txTick;

   esl_fifo #(
      .WIDTH(`ESL_DATA_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(clk),
      .rstN(rstN),
      .inValid(txWrite),
      .inReady(txWriteReady),
      .inData(txWriteData),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData)
   );

   assign txDiv = bitCycles(bitRateSelect);
   assign txLoad = (txStateQ == esl_pkg::ESL_TX_IDLE) && fifoValid && farReady;
   assign fifoPop = txLoad;
   assign txTick = (txStateQ == esl_pkg::ESL_TX_SEND) && (txCntQ >= txDiv - CW'(1));

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         txStateQ <= esl_pkg::ESL_TX_IDLE;
      end else if (txLoad) begin
         txStateQ <= esl_pkg::ESL_TX_SEND;
      end else if (txTick && txIdxQ == `ESL_TX_LAST_BIT) begin
         txStateQ <= esl_pkg::ESL_TX_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         txCntQ <= `ESL_CNT_ZERO;
      end else if (txLoad || txTick) begin
         txCntQ <= `ESL_CNT_ZERO;
      end else if (txStateQ == esl_pkg::ESL_TX_SEND) begin
         txCntQ <= txCntQ + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         txIdxQ <= `ESL_IDX_ZERO;
      end else if (txLoad) begin
         txIdxQ <= `ESL_IDX_ZERO;
      end else if (txTick) begin
         txIdxQ <= txIdxQ + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         txShiftQ <= 10'h3ff;
         txdQ <= 1'b1;
      end else if (txLoad) begin
         txShiftQ <= {1'b1, ^fifoData, fifoData};
         txdQ <= 1'b0;
      end else if (txTick && txIdxQ != `ESL_TX_LAST_BIT) begin
         txShiftQ <= {1'b1, txShiftQ[9:1]};
         txdQ <= txShiftQ[0];
      end
   end

   assign txd = txdQ;
   // nothing queued, nothing on the line
   assign txBufferEmpty = !fifoValid && (txStateQ == esl_pkg::ESL_TX_IDLE);

   // ------------------------------------------
   // receive path
   // ------------------------------------------
   // no signal shared with the transmit path except the rate select
   esl_pkg::esl_rx_state_t rxStateQ;
   logic [CW-1:0] rxDiv;
   logic [CW-1:0] rxCntQ;
   logic [3:0] rxIdxQ;
   logic [9:0] rxShiftQ;
   logic [9:0] rxShiftNext;
   logic rxHalf;
   logic rxTick;
   logic rxDone;
   logic rxStore;
   logic [7:0] rxDataQ;
   logic rxFullQ;
   logic rxParQ;
   logic rxFrmQ;
   logic rxOvrQ;

   assign rxDiv = bitCycles(bitRateSelect);
   assign rxHalf = (rxStateQ == esl_pkg::ESL_RX_START) && (rxCntQ >= (rxDiv >> 1));
   assign rxTick = (rxStateQ == esl_pkg::ESL_RX_DATA) && (rxCntQ >= rxDiv - CW'(1));
   assign rxShiftNext = {rxLine, rxShiftQ[9:1]};
   assign rxDone = rxTick && (rxIdxQ == `ESL_RX_LAST_BIT);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxStateQ <= esl_pkg::ESL_RX_IDLE;
      end else begin
         unique case (rxStateQ)
            esl_pkg::ESL_RX_IDLE: begin
               if (rxPrevQ && !rxLine) begin
                  rxStateQ <= esl_pkg::ESL_RX_START;
               end
            end
            // a start bit gone high by mid period was a glitch
            esl_pkg::ESL_RX_START: begin
               if (rxHalf) begin
                  rxStateQ <= rxLine ? esl_pkg::ESL_RX_IDLE : esl_pkg::ESL_RX_DATA;
               end
            end
            esl_pkg::ESL_RX_DATA: begin
               if (rxDone) begin
                  rxStateQ <= esl_pkg::ESL_RX_IDLE;
               end
            end
            default: begin
               rxStateQ <= esl_pkg::ESL_RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxCntQ <= `ESL_CNT_ZERO;
      end else if (rxStateQ == esl_pkg::ESL_RX_IDLE || rxHalf || rxTick) begin
         rxCntQ <= `ESL_CNT_ZERO;
      end else begin
         rxCntQ <= rxCntQ + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxIdxQ <= `ESL_IDX_ZERO;
      end else if (rxHalf) begin
         rxIdxQ <= `ESL_IDX_ZERO;
      end else if (rxTick) begin
         rxIdxQ <= rxIdxQ + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxShiftQ <= 10'h000;
      end else if (rxTick) begin
         rxShiftQ <= rxShiftNext;
      end
   end

   // a frame finishing while the buffer is full and not read in that cycle is dropped, not merged
   assign rxStore = rxDone && (!rxFullQ || rxRead);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxDataQ <= 8'h00;
         rxParQ <= 1'b0;
         rxFrmQ <= 1'b0;
      end else if (rxStore) begin
         rxDataQ <= rxShiftNext[7:0];
         rxParQ <= ^rxShiftNext[8:0];
         rxFrmQ <= !rxShiftNext[9];
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxFullQ <= 1'b0;
      end else if (rxStore) begin
         rxFullQ <= 1'b1;
      end else if (rxRead) begin
         rxFullQ <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxOvrQ <= 1'b0;
      end else if (rxDone && rxFullQ && !rxRead) begin
         rxOvrQ <= 1'b1;
      end else if (rxRead) begin
         rxOvrQ <= 1'b0;
      end
   end

   assign rxReadData = rxDataQ;
   assign rxAvailable = rxFullQ;
   assign rxParityError = rxParQ;
   assign rxFramingError = rxFrmQ;
   assign rxOverrun = rxOvrQ;
   assign engineReadyN = rxFullQ;
endmodule : engine_serial_link_uart

// ### core/esl_params.svh
/*
 holds the constants of the serial link uart: clock, bit rates, frame shape, fifo depth.
 assumes it is included by bare name before any module that uses it.
*/
`ifndef ESL_PARAMS_SVH
`define ESL_PARAMS_SVH

// ------------------------------------------
// clock and bit rates
// ------------------------------------------
`define ESL_CLK_HZ 50000000
`define ESL_RATE_FAST_BPS 187500
`define ESL_RATE_MID_BPS 62500
`define ESL_RATE_SLOW_BPS 31250
`define ESL_SEL_FAST 2'h0
`define ESL_SEL_MID 2'h1

// ------------------------------------------
// frame shape and counters
// ------------------------------------------
`define ESL_DATA_BITS 8
`define ESL_TX_LAST_BIT 4'ha
`define ESL_RX_LAST_BIT 4'h9
`define ESL_CNT_W 12
`define ESL_CNT_ZERO 12'h000
`define ESL_IDX_ZERO 4'h0
`define ESL_TX_FIFO_DEPTH 16

`endif

// ### core/esl_pkg.sv
/*
 holds the state types of the serial link uart.
 assumes nothing beyond a SystemVerilog compiler.
*/
package esl_pkg;
   typedef enum logic [0:0] {
      ESL_TX_IDLE = 1'b0,
      ESL_TX_SEND = 1'b1
   } esl_tx_state_t;

   typedef enum logic [1:0] {
      ESL_RX_IDLE = 2'b00,
      ESL_RX_START = 2'b01,
      ESL_RX_DATA = 2'b10
   } esl_rx_state_t;
endpackage : esl_pkg

// ### tb/engine_serial_link_uart_bench.sv
/*
 self-checking bench of the serial link uart with a far end model.
 assumes a lowered CLK_HZ so bits last 8, 24 and 48 clocks.
*/
`timescale 1ns/10ps
module engine_serial_link_uart_bench;
   localparam int CLK = 1500000;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] bitRateSelect = 2'h0;
   logic txWrite = 1'b0;
   logic [7:0] txWriteData = 8'h00;
   logic rxRead = 1'b0;
   logic stall = 1'b0;
   logic [7:0] bitClk;
   logic txWriteReady, rxAvailable, txBufferEmpty, rxParityError, rxFramingError, rxOverrun;
   logic txd, rxd, farEndReadyN, engineReadyN;
   logic [7:0] rxReadData;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   assign bitClk = 8'(bitRateSelect == 2'h0 ? CLK / 187500 : bitRateSelect == 2'h1 ? CLK / 62500 : CLK / 31250);
   engine_serial_link_uart #(.CLK_HZ(CLK), .FIFO_DEPTH(16)) uut (.clk(clk), .reset_n(reset_n),
      .bitRateSelect(bitRateSelect), .txWrite(txWrite), .txWriteData(txWriteData), .txWriteReady(txWriteReady),
      .rxRead(rxRead), .rxReadData(rxReadData), .rxAvailable(rxAvailable), .txBufferEmpty(txBufferEmpty),
      .rxParityError(rxParityError), .rxFramingError(rxFramingError), .rxOverrun(rxOverrun), .txd(txd),
      .rxd(rxd), .farEndReadyN(farEndReadyN), .engineReadyN(engineReadyN));
   esl_far_end far (.clk(clk), .txd(txd), .engineReadyN(engineReadyN), .stall(stall), .bitClk(bitClk),
      .rxd(rxd), .farEndReadyN(farEndReadyN));
   task automatic report_and_stop;
      if (errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic put(input logic [7:0] b, input int n);
      txWrite <= 1'b1;
      for (int i = 0; i < n; i++) begin
         txWriteData <= b + 8'(i);
         @(posedge clk);
      end
      txWrite <= 1'b0;
   endtask : put
   task automatic got(input int n, input logic [7:0] exp);
      int k;
      k = 0;
      while (far.gotQ.size() < n && k < 6000) begin
         @(posedge clk);
         k++;
      end
      cmp("tx byte", exp, far.gotQ.pop_front());
      cmp("tx frame ok", 8'h01, 8'(far.gotOk.pop_front()));
   endtask : got
   task automatic take(input logic [7:0] exp, input logic [2:0] flags);
      int k;
      k = 0;
      while (rxAvailable !== 1'b1 && k < 6000) begin
         @(posedge clk);
         k++;
      end
      cmp("rx byte", exp, rxReadData);
      cmp("rx flags", {5'h01, flags}, {4'h0, engineReadyN, rxParityError, rxFramingError, rxOverrun});
      rxRead <= 1'b1;
      @(posedge clk);
      rxRead <= 1'b0;
      @(posedge clk);
      cmp("rx freed", 8'h00, {5'h00, rxAvailable, engineReadyN, rxOverrun});
   endtask : take
   task automatic t_duplex;
      logic [7:0] pat[4];
      pat = '{8'h5a, 8'h01, 8'h80, 8'hff};
      for (int r = 0; r < 4; r++) begin
         bitRateSelect <= 2'(r);
         @(posedge clk);
         fork
            put(pat[r], 1);
            far.send(~pat[r], 1'b0, 1'b0, 1'b0);
         join
         got(1, pat[r]);
         take(~pat[r], 3'h0);
         while (txBufferEmpty !== 1'b1) @(posedge clk);
      end
      bitRateSelect <= 2'h0;
      @(posedge clk);
   endtask : t_duplex
   task automatic t_fifo;
      stall <= 1'b1;
      @(posedge clk);
      put(8'h40, 16);
      @(posedge clk);
      cmp("fifo ready", 8'h00, {7'h00, txWriteReady});
      put(8'hee, 1);
      repeat (40) @(posedge clk);
      cmp("held txd", 8'h01, {7'h00, txd});
      stall <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         got(1, 8'h40 + 8'(i));
      end
      while (txBufferEmpty !== 1'b1) @(posedge clk);
      cmp("extra frames", 8'h00, 8'(far.gotQ.size()));
   endtask : t_fifo
   task automatic t_faults;
      far.send(8'h96, 1'b1, 1'b0, 1'b0);
      take(8'h96, 3'h4);
      far.send(8'h3c, 1'b0, 1'b1, 1'b0);
      take(8'h3c, 3'h2);
      far.send(8'h11, 1'b0, 1'b0, 1'b0);
      far.send(8'h22, 1'b0, 1'b0, 1'b1);
      take(8'h11, 3'h1);
   endtask : t_faults
   initial begin
      repeat (10) @(posedge clk);
      cmp("reset state", 8'h98, {txd, engineReadyN, rxAvailable, txBufferEmpty, txWriteReady, rxParityError,
         rxFramingError, rxOverrun});
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_duplex();
      t_fifo();
      t_faults();
      report_and_stop();
   end
endmodule : engine_serial_link_uart_bench
bind engine_serial_link_uart esl_uart_properties #(.CLK_HZ(CLK_HZ), .FIFO_DEPTH(FIFO_DEPTH)) chk (.clk(clk),
   .reset_n(reset_n), .bitRateSelect(bitRateSelect), .txWrite(txWrite), .txWriteData(txWriteData),
   .txWriteReady(txWriteReady), .rxRead(rxRead), .rxReadData(rxReadData), .rxAvailable(rxAvailable),
   .txBufferEmpty(txBufferEmpty), .rxParityError(rxParityError), .rxFramingError(rxFramingError),
   .rxOverrun(rxOverrun), .txd(txd), .rxd(rxd), .farEndReadyN(farEndReadyN), .engineReadyN(engineReadyN));

// ### tb/esl_far_end.sv
/*
 behavioural data path controller on the far side of the link.
 assumes bitClk gives the clocks per bit of the rate in use.
*/
`timescale 1ns/10ps
module esl_far_end (
   input wire logic clk,
   input wire logic txd,
   input wire logic engineReadyN,
   input wire logic stall,
   input wire logic [7:0] bitClk,
   output logic rxd,
   output logic farEndReadyN
);
   logic [7:0] gotQ[$];
   bit gotOk[$];
   initial rxd = 1'b1;
   assign farEndReadyN = stall;
   task automatic send(input logic [7:0] b, input bit badPar, input bit badStop, input bit ignoreReady);
      logic [10:0] f;
      f = {~badStop, (^b) ^ badPar, b, 1'b0};
      while (engineReadyN !== 1'b0 && !ignoreReady) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (bitClk) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (bitClk) @(posedge clk);
   endtask : send
   // timing from each start edge, lsb first
   initial forever begin
      logic [10:0] s;
      @(negedge txd);
      repeat (bitClk / 2) @(posedge clk);
      s[0] = txd;
      for (int i = 1; i < 11; i++) begin
         repeat (bitClk) @(posedge clk);
         s[i] = txd;
      end
      gotQ.push_back(s[8:1]);
      gotOk.push_back(!s[0] && s[10] && !(^s[9:1]));
   end
endmodule : esl_far_end

// ### tb/esl_uart_properties.sv
/*
 checker of the serial link uart top ports.
 assumes it is bound to engine_serial_link_uart by name.
*/
`timescale 1ns/10ps
module esl_uart_properties #(
   parameter int CLK_HZ = 50000000,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] bitRateSelect,
   input wire logic txWrite,
   input wire logic [7:0] txWriteData,
   input wire logic txWriteReady,
   input wire logic rxRead,
   input wire logic [7:0] rxReadData,
   input wire logic rxAvailable,
   input wire logic txBufferEmpty,
   input wire logic rxParityError,
   input wire logic rxFramingError,
   input wire logic rxOverrun,
   input wire logic txd,
   input wire logic rxd,
   input wire logic farEndReadyN,
   input wire logic engineReadyN
);
   // longest legal low run: start, eight zeros and a zero parity at the slowest rate
   localparam int LOW_MAX = 10 * ((CLK_HZ + 15625) / 31250) + 2;
   logic [15:0] lowCnt_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt_q <= 16'h0000;
      end else if (txd) begin
         lowCnt_q <= 16'h0000;
      end else begin
         lowCnt_q <= lowCnt_q + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_write; txWrite && txWriteReady; endsequence
   sequence s_read; rxRead; endsequence
   chk_reset_idle: assert property ($rose(reset_n) |-> txd && txBufferEmpty && !engineReadyN)
      else $error("link not idle after reset");
   chk_ready_mirror: assert property (engineReadyN == rxAvailable)
      else $error("engine ready disagrees with buffer");
   chk_write_taken: assert property (s_write |=> !txBufferEmpty)
      else $error("write did not occupy transmit path");
   chk_full_cause: assert property ($fell(txWriteReady) |-> $past(txWrite))
      else $error("fifo filled without a write");
   chk_empty_idle: assert property (txBufferEmpty |-> txd)
      else $error("txd low while transmitter idle");
   chk_stop_seen: assert property (lowCnt_q <= LOW_MAX)
      else $error("txd low too long, stop bit missing");
   chk_read_frees: assert property (s_read |=> !rxAvailable && !engineReadyN)
      else $error("read did not free buffer");
   chk_data_hold: assert property (rxAvailable && !rxRead |=> rxAvailable && $stable(rxReadData))
      else $error("stored byte changed before read");
   chk_flag_store: assert property ($rose(rxParityError) || $rose(rxFramingError) |-> rxAvailable)
      else $error("error flag without stored byte");
   chk_overrun_full: assert property ($rose(rxOverrun) |-> $past(rxAvailable))
      else $error("overrun while buffer free");
endmodule : esl_uart_properties
